/* File: hw/port_pkg.sv */
// Purpose: constants and carriers for the port pin function mux
// Assumes: one 10 MHz clock, active-low asynchronous reset
// Notes on behaviour
// - port zero bit 0 is input only; bits 1..3 bidirectional, per-bit direction
// - each bidirectional input bit has a software pull-up enable
// - after reset every pin is an input, alternate outputs included
// - port one is eight bits, each bit doubles as an analog channel
// - analog use needs input mode; device drops pull-ups on analog pins
// - port zero bits 1..3 are edge-selectable external interrupt inputs
// - port three bit 5 carries clock output, bit 6 buzzer output
// - port seven: bit 0 serial in, bit 1 serial out, bit 2 serial clock
// - three-wire mode: port seven bit 2 clock is input or output
// - asynchronous mode: port seven bit 2 is only a baud clock input
// - port ten bits are timer count inputs or timer outputs
package port_pkg;
    localparam int P0_W = 4;
    localparam int P8_W = 8;
    localparam int P7_W = 3;
    localparam int P10_W = 2;
    localparam int IRQ_W = 3;
    localparam int P3_CLK_BIT = 5;
    localparam int P3_BUZ_BIT = 6;
    localparam int P7_SIN_BIT = 0;
    localparam int P7_SOUT_BIT = 1;
    localparam int P7_SCK_BIT = 2;
    localparam logic [7:0] DIR_IN_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] PULL_RST = 8'h00;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // software view of one port: latch, direction (1=output), pull-up enable
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] out_en;
        logic [7:0] pull_en;
    } port_ctrl_type;

    // pin face of one port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } port_drive_type;

    typedef enum logic {SER_THREE_WIRE, SER_ASYNC} serial_mode_type;
endpackage

/* File: hw/port_bit_group.sv */
// Purpose: synchronise pins and form drive for one port of up to eight bits
// Assumes: direction bit high means output
// Notes: pull-up only applies to bits that are inputs
`timescale 1ns/1ns
`default_nettype none
module port_bit_group #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire port_pkg::port_ctrl_type i_ctrl,
    input wire logic [7:0] i_alt_oe,
    input wire logic [7:0] i_alt_out,
    input wire logic [7:0] i_pull_block,
    input wire logic [7:0] i_pin,
    output port_pkg::port_drive_type o_drive,
    output logic [7:0] o_read
);
    import port_pkg::*;
    logic [7:0] meta_q;
    logic [7:0] sync_q;
    logic [7:0] mask;
    // low WIDTH bits set; bits above the port never drive, pull or read
    assign mask = 8'(16'h00ff >> (P8_W - WIDTH));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= LATCH_RST;
            sync_q <= LATCH_RST;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_drive <= '0;
            o_read <= LATCH_RST;
        end else begin
            o_drive.oe <= (i_ctrl.out_en | i_alt_oe) & mask;
            o_drive.out <= ((i_ctrl.latch & ~i_alt_oe) | (i_alt_out & i_alt_oe)) & mask;
            o_drive.pull <= i_ctrl.pull_en & ~i_ctrl.out_en & ~i_alt_oe & ~i_pull_block & mask;
            o_read <= ((i_ctrl.out_en & i_ctrl.latch) | (~i_ctrl.out_en & sync_q)) & mask;
        end
    end

    pull_input_only_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_drive.pull & o_drive.oe) == 8'h00)
        else $error("pull-up active on a driven bit");
endmodule // port_bit_group
`default_nettype wire

/* File: hw/port_pin_function_mux.sv */
// Purpose: parallel port pin control with alternate function sharing
// Assumes: peripherals on the same clock; pins are asynchronous
// Notes: all ports come out of reset as inputs with pull-ups off
`timescale 1ns/1ns
`default_nettype none
module port_pin_function_mux (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire port_pkg::port_ctrl_type i_p0_ctrl,
    input wire port_pkg::port_ctrl_type i_p1_ctrl,
    input wire port_pkg::port_ctrl_type i_p3_ctrl,
    input wire port_pkg::port_ctrl_type i_p5_ctrl,
    input wire port_pkg::port_ctrl_type i_p7_ctrl,
    input wire port_pkg::port_ctrl_type i_p10_ctrl,
    input wire logic [7:0] i_p0_pin,
    input wire logic [7:0] i_p1_pin,
    input wire logic [7:0] i_p3_pin,
    input wire logic [7:0] i_p5_pin,
    input wire logic [7:0] i_p7_pin,
    input wire logic [7:0] i_p10_pin,
    input wire logic [7:0] i_analog_sel,
    input wire logic [5:0] i_irq_edge_sel,
    input wire logic i_clk_out_en,
    input wire logic i_clk_out_val,
    input wire logic i_buzzer_en,
    input wire logic i_buzzer_val,
    input wire port_pkg::serial_mode_type i_serial_mode,
    input wire logic i_serial_en,
    input wire logic i_serial_data_out,
    input wire logic i_serial_clk_master,
    input wire logic i_serial_clk_out,
    input wire logic [1:0] i_timer_out_en,
    input wire logic [1:0] i_timer_out_val,
    output port_pkg::port_drive_type o_p0_drive,
    output port_pkg::port_drive_type o_p1_drive,
    output port_pkg::port_drive_type o_p3_drive,
    output port_pkg::port_drive_type o_p5_drive,
    output port_pkg::port_drive_type o_p7_drive,
    output port_pkg::port_drive_type o_p10_drive,
    output logic [7:0] o_p0_read,
    output logic [7:0] o_p1_read,
    output logic [7:0] o_p3_read,
    output logic [7:0] o_p5_read,
    output logic [7:0] o_p7_read,
    output logic [7:0] o_p10_read,
    output logic [2:0] o_ext_irq_pulse,
    output logic o_sync_serial_data_in,
    output logic o_sync_serial_clock,
    output logic o_async_baud_clock_in,
    output logic [1:0] o_timer_count_in,
    output logic [7:0] o_analog_channel_inputs
);
    import port_pkg::*;

    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        edge_hit = ((sel == EDGE_RISE || sel == EDGE_BOTH) && !prev && cur)
            || ((sel == EDGE_FALL || sel == EDGE_BOTH) && prev && !cur);
    endfunction

    port_ctrl_type p0_ctrl;
    port_ctrl_type p1_ctrl;
    port_ctrl_type p7_ctrl;
    logic [7:0] p3_alt_oe;
    logic [7:0] p3_alt_out;
    logic [7:0] p7_alt_oe;
    logic [7:0] p7_alt_out;
    logic [7:0] p10_alt_oe;
    logic [7:0] p10_alt_out;
    logic three_wire_master;

    // bit 0 never drives and has no pull-up
    always_comb begin
        p0_ctrl = i_p0_ctrl;
        p0_ctrl.out_en[0] = 1'b0;
        p0_ctrl.pull_en[0] = 1'b0;
    end

    // analog bits forced to input so the converter sees the pin undriven
    always_comb begin
        p1_ctrl = i_p1_ctrl;
        p1_ctrl.out_en = i_p1_ctrl.out_en & ~i_analog_sel;
    end

    assign three_wire_master = i_serial_en && i_serial_mode == SER_THREE_WIRE
        && i_serial_clk_master;

    // async mode must never let software drive the baud clock pin
    always_comb begin
        p7_ctrl = i_p7_ctrl;
        if (i_serial_en && i_serial_mode == SER_ASYNC) begin
            p7_ctrl.out_en[P7_SCK_BIT] = 1'b0;
        end
    end

    always_comb begin
        p3_alt_oe = 8'h00;
        p3_alt_out = 8'h00;
        p3_alt_oe[P3_CLK_BIT] = i_clk_out_en;
        p3_alt_out[P3_CLK_BIT] = i_clk_out_val;
        p3_alt_oe[P3_BUZ_BIT] = i_buzzer_en;
        p3_alt_out[P3_BUZ_BIT] = i_buzzer_val;
        p7_alt_oe = 8'h00;
        p7_alt_out = 8'h00;
        p7_alt_oe[P7_SOUT_BIT] = i_serial_en;
        p7_alt_out[P7_SOUT_BIT] = i_serial_data_out;
        p7_alt_oe[P7_SCK_BIT] = three_wire_master;
        p7_alt_out[P7_SCK_BIT] = i_serial_clk_out;
        p10_alt_oe = {6'h00, i_timer_out_en};
        p10_alt_out = {6'h00, i_timer_out_val};
    end

    port_bit_group #(.WIDTH(P0_W)) u_p0 (.i_clk(i_clk), .i_rst_n(rst_n_q), .i_ctrl(p0_ctrl),
        .i_alt_oe(8'h00), .i_alt_out(8'h00), .i_pull_block(8'h00), .i_pin(i_p0_pin),
        .o_drive(o_p0_drive), .o_read(o_p0_read));
    port_bit_group #(.WIDTH(P8_W)) u_p1 (.i_clk(i_clk), .i_rst_n(rst_n_q), .i_ctrl(p1_ctrl),
        .i_alt_oe(8'h00), .i_alt_out(8'h00), .i_pull_block(i_analog_sel),
        .i_pin(i_p1_pin), .o_drive(o_p1_drive), .o_read(o_p1_read));
    port_bit_group #(.WIDTH(P8_W)) u_p3 (.i_clk(i_clk), .i_rst_n(rst_n_q), .i_ctrl(i_p3_ctrl),
        .i_alt_oe(p3_alt_oe), .i_alt_out(p3_alt_out), .i_pull_block(8'h00),
        .i_pin(i_p3_pin), .o_drive(o_p3_drive), .o_read(o_p3_read));
    port_bit_group #(.WIDTH(P8_W)) u_p5 (.i_clk(i_clk), .i_rst_n(rst_n_q), .i_ctrl(i_p5_ctrl),
        .i_alt_oe(8'h00), .i_alt_out(8'h00), .i_pull_block(8'h00),
        .i_pin(i_p5_pin), .o_drive(o_p5_drive), .o_read(o_p5_read));
    port_bit_group #(.WIDTH(P7_W)) u_p7 (.i_clk(i_clk), .i_rst_n(rst_n_q), .i_ctrl(p7_ctrl),
        .i_alt_oe(p7_alt_oe), .i_alt_out(p7_alt_out), .i_pull_block(8'h00),
        .i_pin(i_p7_pin), .o_drive(o_p7_drive), .o_read(o_p7_read));
    port_bit_group #(.WIDTH(P10_W)) u_p10 (.i_clk(i_clk), .i_rst_n(rst_n_q), .i_ctrl(i_p10_ctrl),
        .i_alt_oe(p10_alt_oe), .i_alt_out(p10_alt_out), .i_pull_block(8'h00),
        .i_pin(i_p10_pin), .o_drive(o_p10_drive), .o_read(o_p10_read));

    // alternate inputs from their own two-stage synchronisers
    logic [2:0] irq_meta_q;
    logic [2:0] irq_sync_q;
    logic [2:0] irq_prev_q;
    logic [3:0] alt_meta_q;
    logic [3:0] alt_sync_q;
    logic [7:0] ana_meta_q;
    logic [7:0] ana_sync_q;
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_meta_q <= 3'h0;
            irq_sync_q <= 3'h0;
            irq_prev_q <= 3'h0;
        end else begin
            irq_meta_q <= i_p0_pin[IRQ_W:1];
            irq_sync_q <= irq_meta_q;
            irq_prev_q <= irq_sync_q;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_ext_irq_pulse <= 3'h0;
        end else begin
            for (int k = 0; k < IRQ_W; k++) begin
                o_ext_irq_pulse[k] <= edge_hit(i_irq_edge_sel[2*k +: 2], irq_prev_q[k],
                    irq_sync_q[k]);
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            alt_meta_q <= 4'h0;
            alt_sync_q <= 4'h0;
            ana_meta_q <= 8'h00;
            ana_sync_q <= 8'h00;
            o_analog_channel_inputs <= 8'h00;
            o_sync_serial_data_in <= 1'b0;
            o_sync_serial_clock <= 1'b0;
            o_async_baud_clock_in <= 1'b0;
            o_timer_count_in <= 2'h0;
        end else begin
            // shared clock pin synchronised once for both serial modes
            alt_meta_q <= {i_p10_pin[1:0], i_p7_pin[P7_SCK_BIT], i_p7_pin[P7_SIN_BIT]};
            alt_sync_q <= alt_meta_q;
            // select applied after the second flop so no logic reads a raw pin
            ana_meta_q <= i_p1_pin;
            ana_sync_q <= ana_meta_q;
            o_analog_channel_inputs <= ana_sync_q & i_analog_sel;
            o_sync_serial_data_in <= alt_sync_q[0];
            // in master mode the clock seen internally is our own
            o_sync_serial_clock <= three_wire_master ? i_serial_clk_out : alt_sync_q[1];
            o_async_baud_clock_in <= (i_serial_mode == SER_ASYNC) & alt_sync_q[1];
            o_timer_count_in <= alt_sync_q[3:2] & ~i_timer_out_en;
        end
    end

    after_reset_input_a: assert property (@(posedge i_clk)
        $rose(rst_n_q) |-> (o_p3_drive.oe == 8'h00 && o_p7_drive.oe == 8'h00
        && o_p10_drive.oe == 8'h00 && o_p0_drive.oe == 8'h00
        && o_p1_drive.oe == 8'h00 && o_p5_drive.oe == 8'h00))
        else $error("pin driven right after reset");
    p0_bit0_input_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        !o_p0_drive.oe[0] && !o_p0_drive.pull[0])
        else $error("input-only bit driven or pulled");
    analog_no_pull_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        $stable(i_analog_sel) && $stable(i_p1_ctrl) |=> ((o_p1_drive.pull | o_p1_drive.oe)
        & $past(i_analog_sel)) == 8'h00)
        else $error("analog pin pulled or driven");
    async_sck_input_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        i_serial_en && i_serial_mode == SER_ASYNC ##1 i_serial_en && i_serial_mode == SER_ASYNC
        |-> !o_p7_drive.oe[P7_SCK_BIT])
        else $error("baud clock pin driven in async mode");
    buzzer_route_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        i_buzzer_en |=> o_p3_drive.oe[P3_BUZ_BIT] && o_p3_drive.out[P3_BUZ_BIT]
        == $past(i_buzzer_val))
        else $error("buzzer not routed to port three bit six");
    sck_master_out_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        three_wire_master |=> o_p7_drive.oe[P7_SCK_BIT])
        else $error("three-wire master clock not driven");
    timer_out_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        i_timer_out_en[0] |=> o_p10_drive.oe[0]
        && o_p10_drive.out[0] == $past(i_timer_out_val[0]))
        else $error("timer output not on port ten");
    irq_rise_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        i_irq_edge_sel[1:0] == EDGE_RISE && irq_sync_q[0] && !irq_prev_q[0]
        |=> o_ext_irq_pulse[0])
        else $error("rising edge missed on interrupt input");
    readback_out_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        i_p5_ctrl.out_en[3] |=> o_p5_read[3] == $past(i_p5_ctrl.latch[3]))
        else $error("output bit reads back wrong value");
endmodule // port_pin_function_mux
`default_nettype wire

/* File: verification/board_pins.sv */
// Purpose: board circuitry seen by the pins of one port
// Assumes: the board source is weak, so device drive and pull-up both beat it
// Notes: bits above the port width are driven too; the device ignores them
`timescale 1ns/1ns
`default_nettype none
module board_pins (
    input wire port_pkg::port_drive_type i_drive,
    input wire logic [7:0] i_ext,
    output logic [7:0] o_pin
);
    import port_pkg::*;
    // weak board source: a pulled-up input always settles high
    assign o_pin = (i_drive.oe & i_drive.out) | (~i_drive.oe & (i_drive.pull | i_ext));
endmodule // board_pins
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: self-checking bench for the port pin function mux
// Assumes: one 100 ns clock, inputs changed on the falling edge
// Notes: expected pin levels come from the board rules, not from the outputs
`timescale 1ns/1ns
`default_nettype none
module tb;
    import port_pkg::*;
    localparam logic [7:0] WMASK [6] = '{8'h0f, 8'hff, 8'hff, 8'hff, 8'h07, 8'h03};
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    port_ctrl_type ctrl [6];
    port_drive_type drv [6];
    logic [7:0] ext [6];
    logic [7:0] pin [6];
    logic [7:0] rd [6];
    logic [7:0] pc [3];
    logic [7:0] analog_sel, analog_q;
    logic [5:0] edge_sel;
    logic clk_en, clk_val, buz_en, buz_val, ser_en, ser_do, ser_mst, ser_ck, sdi, sck, baud;
    serial_mode_type ser_mode;
    logic [1:0] tmr_en, tmr_val, tcnt;
    logic [2:0] irq;
    int err_count = 0;
    int n_compared = 0;

    always #50 i_clk = ~i_clk;

    port_pin_function_mux port_pin_function_mux_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_p0_ctrl(ctrl[0]), .i_p1_ctrl(ctrl[1]), .i_p3_ctrl(ctrl[2]), .i_p5_ctrl(ctrl[3]),
        .i_p7_ctrl(ctrl[4]), .i_p10_ctrl(ctrl[5]), .i_p0_pin(pin[0]), .i_p1_pin(pin[1]),
        .i_p3_pin(pin[2]), .i_p5_pin(pin[3]), .i_p7_pin(pin[4]), .i_p10_pin(pin[5]),
        .i_analog_sel(analog_sel), .i_irq_edge_sel(edge_sel), .i_clk_out_en(clk_en),
        .i_clk_out_val(clk_val), .i_buzzer_en(buz_en), .i_buzzer_val(buz_val),
        .i_serial_mode(ser_mode), .i_serial_en(ser_en), .i_serial_data_out(ser_do),
        .i_serial_clk_master(ser_mst), .i_serial_clk_out(ser_ck), .i_timer_out_en(tmr_en),
        .i_timer_out_val(tmr_val), .o_p0_drive(drv[0]), .o_p1_drive(drv[1]),
        .o_p3_drive(drv[2]), .o_p5_drive(drv[3]), .o_p7_drive(drv[4]), .o_p10_drive(drv[5]),
        .o_p0_read(rd[0]), .o_p1_read(rd[1]), .o_p3_read(rd[2]), .o_p5_read(rd[3]),
        .o_p7_read(rd[4]), .o_p10_read(rd[5]), .o_ext_irq_pulse(irq),
        .o_sync_serial_data_in(sdi), .o_sync_serial_clock(sck), .o_async_baud_clock_in(baud),
        .o_timer_count_in(tcnt), .o_analog_channel_inputs(analog_q));

    for (genvar g = 0; g < 6; g++) begin : g_brd
        board_pins board_pins_i (.i_drive(drv[g]), .i_ext(ext[g]), .o_pin(pin[g]));
    end

    // counting every high cycle also catches a pulse that stands too long
    logic pc_clr = 1'b1;
    always @(posedge i_clk) begin
        for (int k = 0; k < 3; k++) pc[k] <= pc_clr ? 8'h00 : pc[k] + {7'h00, irq[k]};
    end

    function automatic logic [7:0] force_in(int p);
        return p == 0 ? 8'h01 : (p == 1 ? analog_sel : 8'h00);
    endfunction
    function automatic logic [7:0] exp_oe(int p);
        return ctrl[p].out_en & ~force_in(p) & WMASK[p];
    endfunction
    function automatic logic [7:0] exp_pull(int p);
        return ctrl[p].pull_en & ~ctrl[p].out_en & ~force_in(p) & WMASK[p];
    endfunction
    function automatic logic [7:0] exp_pin(int p);
        return (ctrl[p].latch & exp_oe(p)) | (~exp_oe(p) & (exp_pull(p) | ext[p]));
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic test_done;
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(100 * 5000);
        err_count++;
        test_done();
    end

    initial begin
        logic [31:0] r;
        logic [7:0] e7, e10;
        r = $urandom(40085);
        // every port and every alternate output but the timer asks to drive during reset; nothing may
        for (int p = 0; p < 6; p++) begin
            ctrl[p] = 24'hff_ffff;
            ext[p] = 8'h00;
        end
        {clk_en, clk_val, buz_en, buz_val, ser_en, ser_do, ser_mst, ser_ck} = 8'hff;
        {tmr_en, tmr_val, analog_sel, edge_sel} = 18'h0_000f;
        ser_mode = SER_THREE_WIRE;
        tick(10);
        for (int p = 0; p < 6; p++) chk(drv[p].oe | drv[p].pull, 8'h00);
        tick(3);
        i_rst_n = 1'b1;
        {clk_en, buz_en, ser_en, ser_mst, tmr_en} = 6'h00;
        tick(4);
        for (int it = 0; it < 40; it++) begin
            for (int p = 0; p < 6; p++) begin
                r = (it == 0) ? 32'h00ff_ffff : ((it == 1) ? 32'h0000_00ff : $urandom);
                ctrl[p] = r[23:0];
                ext[p] = 8'($urandom);
            end
            analog_sel = (it == 0) ? 8'hff : 8'($urandom);
            ser_mode = serial_mode_type'($urandom_range(1, 0));
            tick(5);
            for (int p = 0; p < 6; p++) begin
                chk(drv[p].oe & WMASK[p], exp_oe(p));
                chk(drv[p].pull & WMASK[p], exp_pull(p));
                chk(drv[p].out & exp_oe(p), ctrl[p].latch & exp_oe(p));
                chk(rd[p] & WMASK[p], exp_pin(p) & WMASK[p]);
            end
            e7 = exp_pin(4);
            e10 = exp_pin(5);
            chk(analog_q, exp_pin(1) & analog_sel);
            chk({6'h00, tcnt}, {6'h00, e10[1:0]});
            chk({6'h00, sdi, baud}, {6'h00, e7[0], ser_mode == SER_ASYNC && e7[2]});
            if (ser_mode == SER_THREE_WIRE) chk({7'h00, sck}, {7'h00, e7[2]});
        end
        for (int p = 0; p < 6; p++) ctrl[p] = 24'h00_0000;
        {analog_sel, ser_mode} = 9'h000;
        {clk_val, buz_val, ser_do, ser_ck, tmr_val} = 6'($urandom);
        {clk_en, buz_en, ser_en, ser_mst, tmr_en} = 6'h3f;
        tick(3);
        chk({4'h0, drv[2].oe[6:5], drv[2].out[6:5]}, {4'h0, 2'b11, buz_val, clk_val});
        chk({4'h0, drv[4].oe[2:1], drv[4].out[2:1]}, {4'h0, 2'b11, ser_ck, ser_do});
        chk({4'h0, drv[5].oe[1:0], drv[5].out[1:0]}, {4'h0, 2'b11, tmr_val});
        for (int v = 0; v < 2; v++) begin
            {ser_mst, ser_mode, tmr_en} = 4'h0;
            ext[4] = {5'h00, v[0], 2'b00};
            ext[5] = {6'h00, v[0], v[0]};
            tick(5);
            chk({6'h00, drv[4].oe[2], sck}, {7'h00, v[0]});
            chk({6'h00, tcnt}, {6'h00, v[0], v[0]});
            ser_mode = SER_ASYNC;
            ctrl[4].out_en[2] = 1'b1;
            tick(5);
            chk({6'h00, drv[4].oe[2], baud}, {7'h00, v[0]});
            ctrl[4].out_en[2] = 1'b0;
        end
        {clk_en, buz_en, ser_en, ser_mst, tmr_en} = 6'h00;
        ext[0] = 8'h00;
        for (int s = 0; s < 4; s++) begin
            edge_sel = {3{s[1:0]}};
            tick(5);
            pc_clr = 1'b1;
            tick(1);
            pc_clr = 1'b0;
            ext[0] = 8'h0e;
            tick(6);
            for (int k = 0; k < 3; k++) chk(pc[k], {7'h00, s[0]});
            pc_clr = 1'b1;
            tick(1);
            pc_clr = 1'b0;
            ext[0] = 8'h00;
            tick(6);
            for (int k = 0; k < 3; k++) chk(pc[k], {7'h00, s[1]});
        end
        test_done();
    end
endmodule // tb
`default_nettype wire
